/* File: core/ppm_pkg.sv */
// package with port pin override mux constants and types
package ppm_pkg;

  // port width and reset values of the software bits
  localparam int PPM_PINS = 6;
  localparam logic PPM_DIR_RST = 1'b0;
  localparam logic PPM_OUT_RST = 1'b0;
  localparam logic PPM_SYNC_RST = 1'b0;

  // register byte offsets on the apb bus
  localparam logic [11:0] PPM_OFF_SAMPLE = 12'h000;
  localparam logic [11:0] PPM_OFF_DIR = 12'h004;
  localparam logic [11:0] PPM_OFF_OUT = 12'h008;
  localparam logic [11:0] PPM_OFF_CTRL = 12'h00c;
  localparam logic [11:0] PPM_OFF_IRQ = 12'h010;

  // control register field positions
  localparam int PPM_CTRL_KILL = 0;
  localparam int PPM_CTRL_SLEEP = 1;

  // interrupt sense encodings
  typedef enum logic [1:0] {
    PPM_SENSE_LEVEL = 2'h0,
    PPM_SENSE_ANY = 2'h1,
    PPM_SENSE_FALL = 2'h2,
    PPM_SENSE_RISE = 2'h3
  } ppm_sense_t;

  // edge event decode, used per pin
  function automatic logic ppm_edge(input ppm_sense_t s, input logic prev, input logic cur);
    unique case (s)
      PPM_SENSE_ANY: ppm_edge = prev != cur;
      PPM_SENSE_FALL: ppm_edge = prev & ~cur;
      PPM_SENSE_RISE: ppm_edge = ~prev & cur;
      PPM_SENSE_LEVEL: ppm_edge = 1'b0;
    endcase
  endfunction

endpackage

/* File: core/ppm_ovr_if.sv */
// per-port bundle of alternate function override signals
`timescale 1ns/1ps
interface ppm_ovr_if #(parameter int N = 6);
  logic [N-1:0] pu_oe;
  logic [N-1:0] pu_ov;
  logic [N-1:0] dd_oe;
  logic [N-1:0] dd_ov;
  logic [N-1:0] pv_oe;
  logic [N-1:0] pv_ov;
  logic [N-1:0] pt_oe;
  logic [N-1:0] ie_oe;
  logic [N-1:0] ie_ov;
  modport src (output pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov, pt_oe, ie_oe, ie_ov);
  modport dst (input pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov, pt_oe, ie_oe, ie_ov);
endinterface

/* File: core/ppm_ovr_gate.sv */
// gates alternate function overrides: enables forced low when no function owns a pin
`timescale 1ns/1ps
module ppm_ovr_gate #(
  parameter int N = 6
) (
  // raw requests from alternate function modules
  input wire logic [N-1:0] alt_active,
  input wire logic [N-1:0] pullup_override_enable,
  input wire logic [N-1:0] pullup_override_value,
  input wire logic [N-1:0] direction_override_enable,
  input wire logic [N-1:0] direction_override_value,
  input wire logic [N-1:0] port_value_override_enable,
  input wire logic [N-1:0] port_value_override_value,
  input wire logic [N-1:0] port_toggle_override_enable,
  input wire logic [N-1:0] input_enable_override_enable,
  input wire logic [N-1:0] input_enable_override_value,
  // gated bundle
  ppm_ovr_if.src ovr
);
  // every enable masked by ownership; values pass unchanged
  assign ovr.pu_oe = pullup_override_enable & alt_active;
  assign ovr.dd_oe = direction_override_enable & alt_active;
  assign ovr.pv_oe = port_value_override_enable & alt_active;
  assign ovr.pt_oe = port_toggle_override_enable & alt_active;
  assign ovr.ie_oe = input_enable_override_enable & alt_active;
  assign ovr.pu_ov = pullup_override_value;
  assign ovr.dd_ov = direction_override_value;
  assign ovr.pv_ov = port_value_override_value;
  assign ovr.ie_ov = input_enable_override_value;
endmodule

/* File: core/ppm_port.sv */
// one general purpose port with alternate function overrides and apb registers
`timescale 1ns/1ps
// Overview of operation
// - sleep clamp grounds input before schmitt
// - enabled external interrupt suppresses the clamp
// - clamp-made edge sets flag on wake
// - pull-ups off while reset active
// - pull-up from override or 0b010 pattern
// - override value alone sets pull-up
// - driver enable from override or direction
// - override value alone sets driver enable
// - driven level from override or output bit
// - override value drives pin, output bit ignored
// - toggle override inverts stored output bit
// - no override: input enable from sleep state
// - override value alone sets input enable
// - schmitt tap given unsynchronised to modules
// - analog line straight to pad
// - strobes per port, sleep/kill shared
// - direction one means output
// - output bit: pull-up input, level output
// - writing one to sample bit toggles output
// - two-stage synchroniser into sample bit
module ppm_port
  import ppm_pkg::*;
#(
  parameter int N = PPM_PINS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sleep controller
  input wire logic sleep_clamp_req,
  // alternate function modules
  input wire logic [N-1:0] alt_active,
  input wire logic [N-1:0] pullup_override_enable,
  input wire logic [N-1:0] pullup_override_value,
  input wire logic [N-1:0] direction_override_enable,
  input wire logic [N-1:0] direction_override_value,
  input wire logic [N-1:0] port_value_override_enable,
  input wire logic [N-1:0] port_value_override_value,
  input wire logic [N-1:0] port_toggle_override_enable,
  input wire logic [N-1:0] input_enable_override_enable,
  input wire logic [N-1:0] input_enable_override_value,
  output logic [N-1:0] schmitt_output_tap,
  // pad side
  input wire logic [N-1:0] pad_in,
  output logic [N-1:0] pad_out,
  output logic [N-1:0] pad_oe,
  output logic [N-1:0] pad_pullup,
  output logic [N-1:0] pad_ie,
  // analog pad line as three signals
  input wire logic [N-1:0] analog_pad_line_in,
  output logic [N-1:0] analog_pad_line_out,
  output logic [N-1:0] analog_pad_line_oe
);

  // refuse pin counts that the register fields cannot hold
  if (N < 1 || N > 8) begin : g_bad_n
    $error("ppm_port: N must be 1..8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // override bundle

  ppm_ovr_if #(.N(N)) ovr ();

  ppm_ovr_gate #(.N(N)) u_gate (
    .alt_active(alt_active),
    .pullup_override_enable(pullup_override_enable),
    .pullup_override_value(pullup_override_value),
    .direction_override_enable(direction_override_enable),
    .direction_override_value(direction_override_value),
    .port_value_override_enable(port_value_override_enable),
    .port_value_override_value(port_value_override_value),
    .port_toggle_override_enable(port_toggle_override_enable),
    .input_enable_override_enable(input_enable_override_enable),
    .input_enable_override_value(input_enable_override_value),
    .ovr(ovr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [N-1:0] pin_direction_bit_q, pin_direction_bit_d;
  logic [N-1:0] pin_output_value_bit_q, pin_output_value_bit_d;
  logic [N-1:0] sync_latch_q, sync_latch_d;
  logic [N-1:0] pin_input_sample_bit_q, pin_input_sample_bit_d;
  logic global_pullup_kill_q, global_pullup_kill_d;
  logic sleep_sw_q, sleep_sw_d;
  logic [N-1:0] irq_en_q, irq_en_d;
  logic [2*N-1:0] irq_sense_q, irq_sense_d;
  logic [N-1:0] irq_flag_q, irq_flag_d;
  logic [N-1:0] prev_in_q, prev_in_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [N-1:0] oe_q, oe_d, out_q, out_d, pu_q, pu_d, ie_q, ie_d, tap_q, tap_d;

  logic sleep_clamp;
  logic [N-1:0] in_en, schmitt;
  logic wr, rd_ok;

  // clamp shared by every pin; the request pin or software bit may raise it
  assign sleep_clamp = sleep_clamp_req | sleep_sw_q;

  // write lands on the access edge that sees pready high, never on setup alone
  assign wr = psel & penable & pready_q & pwrite & pstrb[0];
  assign rd_ok = (paddr == PPM_OFF_SAMPLE) || (paddr == PPM_OFF_DIR) ||
                 (paddr == PPM_OFF_OUT) || (paddr == PPM_OFF_CTRL) || (paddr == PPM_OFF_IRQ);

  ////////////////////////////////////////////////////////////////////////////
  // input path: enable, clamp, schmitt tap, synchroniser

  always_comb begin
    for (int i = 0; i < N; i++) begin
      // interrupt pins keep their input alive in sleep
      if (ovr.ie_oe[i]) begin
        in_en[i] = ovr.ie_ov[i];
      end else begin
        in_en[i] = ~sleep_clamp | irq_en_q[i];
      end
    end
    schmitt = pad_in & in_en;
  end

  // sample latch modelled as flop; the sample bit reads only the latch
  always_comb begin
    sync_latch_d = schmitt;
    pin_input_sample_bit_d = sync_latch_q;
    tap_d = schmitt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // software bits, toggle and interrupt flags

  always_comb begin
    pin_direction_bit_d = pin_direction_bit_q;
    pin_output_value_bit_d = pin_output_value_bit_q;
    global_pullup_kill_d = global_pullup_kill_q;
    sleep_sw_d = sleep_sw_q;
    irq_en_d = irq_en_q;
    irq_sense_d = irq_sense_q;
    irq_flag_d = irq_flag_q;
    if (wr && paddr == PPM_OFF_DIR) begin
      pin_direction_bit_d = pwdata[N-1:0];
    end
    if (wr && paddr == PPM_OFF_OUT) begin
      pin_output_value_bit_d = pwdata[N-1:0];
    end
    if (wr && paddr == PPM_OFF_CTRL) begin
      global_pullup_kill_d = pwdata[PPM_CTRL_KILL];
      sleep_sw_d = pwdata[PPM_CTRL_SLEEP];
    end
    // sample write of one toggles; zero leaves the bit
    if (wr && paddr == PPM_OFF_SAMPLE) begin
      pin_output_value_bit_d = pin_output_value_bit_d ^ pwdata[N-1:0];
    end
    pin_output_value_bit_d = pin_output_value_bit_d ^ ovr.pt_oe;
    // write one to clear, but a new edge in the same cycle wins
    if (wr && paddr == PPM_OFF_IRQ && pstrb[1]) begin
      irq_flag_d = irq_flag_d & ~pwdata[8 +: N];
    end
    if (wr && paddr == PPM_OFF_IRQ) begin
      irq_en_d = pwdata[N-1:0];
      irq_sense_d = pwdata[16 +: 2*N];
    end
    // flags track edges even with the interrupt disabled, so the clamp-made
    // fall on entry and rise on wake both register
    for (int i = 0; i < N; i++) begin
      if (ppm_edge(ppm_sense_t'(irq_sense_q[2*i +: 2]), prev_in_q[i], schmitt[i])) begin
        irq_flag_d[i] = 1'b1;
      end
    end
    prev_in_d = schmitt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad drive, pull-up, analog line

  always_comb begin
    for (int i = 0; i < N; i++) begin
      oe_d[i] = ovr.dd_oe[i] ? ovr.dd_ov[i] : pin_direction_bit_q[i];
      out_d[i] = ovr.pv_oe[i] ? ovr.pv_ov[i] : pin_output_value_bit_q[i];
      if (ovr.pu_oe[i]) begin
        pu_d[i] = ovr.pu_ov[i];
      end else begin
        pu_d[i] = {pin_direction_bit_q[i], pin_output_value_bit_q[i],
                   global_pullup_kill_q} == 3'h2;
      end
    end
    ie_d = in_en;
  end

  // analog line is a straight wire to the pad, never driven by logic
  assign analog_pad_line_out = '0;
  assign analog_pad_line_oe = '0;

  ////////////////////////////////////////////////////////////////////////////
  // apb answer

  always_comb begin
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (psel && !penable) begin
      pready_d = 1'b1;
      pslverr_d = ~rd_ok;
      prdata_d = '0;
      unique case (paddr)
        PPM_OFF_SAMPLE: prdata_d[N-1:0] = pin_input_sample_bit_q;
        PPM_OFF_DIR: prdata_d[N-1:0] = pin_direction_bit_q;
        PPM_OFF_OUT: prdata_d[N-1:0] = pin_output_value_bit_q;
        PPM_OFF_CTRL: prdata_d[1:0] = {sleep_sw_q, global_pullup_kill_q};
        PPM_OFF_IRQ: begin
          prdata_d[N-1:0] = irq_en_q;
          prdata_d[8 +: N] = irq_flag_q;
          prdata_d[16 +: 2*N] = irq_sense_q;
        end
        default: prdata_d = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; pull-up flop clears on reset so pull-ups are off throughout

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_direction_bit_q <= {N{PPM_DIR_RST}};
      pin_output_value_bit_q <= {N{PPM_OUT_RST}};
      sync_latch_q <= {N{PPM_SYNC_RST}};
      pin_input_sample_bit_q <= {N{PPM_SYNC_RST}};
      global_pullup_kill_q <= 1'b0;
      sleep_sw_q <= 1'b0;
      irq_en_q <= '0;
      irq_sense_q <= '0;
      irq_flag_q <= '0;
      prev_in_q <= '0;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      oe_q <= '0;
      out_q <= '0;
      pu_q <= '0;
      ie_q <= '0;
      tap_q <= '0;
    end else begin
      pin_direction_bit_q <= pin_direction_bit_d;
      pin_output_value_bit_q <= pin_output_value_bit_d;
      sync_latch_q <= sync_latch_d;
      pin_input_sample_bit_q <= pin_input_sample_bit_d;
      global_pullup_kill_q <= global_pullup_kill_d;
      sleep_sw_q <= sleep_sw_d;
      irq_en_q <= irq_en_d;
      irq_sense_q <= irq_sense_d;
      irq_flag_q <= irq_flag_d;
      prev_in_q <= prev_in_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      oe_q <= oe_d;
      out_q <= out_d;
      pu_q <= pu_d;
      ie_q <= ie_d;
      tap_q <= tap_d;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pad_oe = oe_q;
  assign pad_out = out_q;
  assign pad_pullup = pu_q;
  assign pad_ie = ie_q;
  assign schmitt_output_tap = tap_q;

endmodule

/* File: verification/ppm_pad_model.sv */
// pad model: resolves each pad level from the driver, the pull-up and an outside source
`timescale 1ns/1ps
module ppm_pad_model #(
  parameter int N = 6
) (
  // clock and outside source
  input wire logic pclk,
  input wire logic [N-1:0] ext_en,
  input wire logic [N-1:0] ext_v,
  // pad controls from the port
  input wire logic [N-1:0] pad_out,
  input wire logic [N-1:0] pad_oe,
  input wire logic [N-1:0] pad_pullup,
  output logic [N-1:0] pad_in
);
  logic [N-1:0] float_q = '0;
  // a floating pad flips every cycle so no test leans on a stale level
  always_ff @(posedge pclk) begin
    float_q <= ~float_q;
  end
  // own driver wins, then the outside source, then the pull-up
  always_comb begin
    pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_v)
           | (~pad_oe & ~ext_en & (pad_pullup | float_q));
  end
endmodule

/* File: verification/ppm_port_checker.sv */
// concurrent checks on the pad and bus outputs of the port
`timescale 1ns/1ps
module ppm_port_checker #(
  parameter int N = 6
) (
  // clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // overrides
  input wire logic [N-1:0] alt_active,
  input wire logic [N-1:0] pullup_override_enable,
  input wire logic [N-1:0] pullup_override_value,
  input wire logic [N-1:0] direction_override_enable,
  input wire logic [N-1:0] direction_override_value,
  input wire logic [N-1:0] port_value_override_enable,
  input wire logic [N-1:0] port_value_override_value,
  input wire logic [N-1:0] input_enable_override_enable,
  input wire logic [N-1:0] input_enable_override_value,
  // pad side
  input wire logic [N-1:0] pad_in,
  input wire logic [N-1:0] schmitt_output_tap,
  input wire logic [N-1:0] pad_out,
  input wire logic [N-1:0] pad_oe,
  input wire logic [N-1:0] pad_pullup,
  input wire logic [N-1:0] pad_ie,
  input wire logic [N-1:0] analog_pad_line_out,
  input wire logic [N-1:0] analog_pad_line_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // overrides that an owning function really applies
  wire [N-1:0] pu_m = alt_active & pullup_override_enable;
  wire [N-1:0] dd_m = alt_active & direction_override_enable;
  wire [N-1:0] pv_m = alt_active & port_value_override_enable;
  wire [N-1:0] ie_m = alt_active & input_enable_override_enable;
  ////////////////////////////////////////
  // reset must not be masked here, it is the very case under watch
  property p_pu_rst;
    disable iff (1'b0) !presetn |-> pad_pullup == '0;
  endproperty
  a_pu_rst: assert property (p_pu_rst) else $error("pull-up on in reset");
  property p_pu_ovr;
    $past(presetn) && |pu_m |=>
      (pad_pullup & $past(pu_m)) == ($past(pullup_override_value) & $past(pu_m));
  endproperty
  a_pu_ovr: assert property (p_pu_ovr) else $error("pull-up ignores override");
  property p_dd_ovr;
    $past(presetn) && |dd_m |=>
      (pad_oe & $past(dd_m)) == ($past(direction_override_value) & $past(dd_m));
  endproperty
  a_dd_ovr: assert property (p_dd_ovr) else $error("driver ignores override");
  property p_pv_ovr;
    $past(presetn) && |pv_m |=>
      (pad_out & $past(pv_m)) == ($past(port_value_override_value) & $past(pv_m));
  endproperty
  a_pv_ovr: assert property (p_pv_ovr) else $error("level ignores override");
  property p_ie_ovr;
    $past(presetn) && |ie_m |=>
      (pad_ie & $past(ie_m)) == ($past(input_enable_override_value) & $past(ie_m));
  endproperty
  a_ie_ovr: assert property (p_ie_ovr) else $error("input enable ignores override");
  property p_tap;
    $past(presetn) |=> schmitt_output_tap == ($past(pad_in) & pad_ie);
  endproperty
  a_tap: assert property (p_tap) else $error("tap high on a low pad");
  property p_ana;
    (analog_pad_line_oe | analog_pad_line_out) == '0;
  endproperty
  a_ana: assert property (p_ana) else $error("analog line driven by logic");
  property p_rdy;
    psel && !penable |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no answer after setup");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  // main scenarios reached
  c_pu: cover property (|pu_m);
  c_dd: cover property (|dd_m);
  c_rdy: cover property (pready);
endmodule
bind ppm_port ppm_port_checker #(.N(N)) u_ppm_port_checker (.*);

/* File: verification/testbench.sv */
// self-checking bench for the port pin override mux
`timescale 1ns/1ps
`define CMP(nm, e, s) begin comparisons++; if ((e) !== (s)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, e, s); end end
module testbench;
  import ppm_pkg::*;
  localparam int N = PPM_PINS;
  typedef struct {logic [2:0] sel; logic [31:0] e;} ppm_note_t;
  logic pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0, pad_chk = 0;
  logic sleep_clamp_req = 0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] pstrb = '0;
  logic [N-1:0] alt_active = '0, pullup_override_enable = '0, pullup_override_value = '0;
  logic [N-1:0] direction_override_enable = '0, direction_override_value = '0;
  logic [N-1:0] port_value_override_enable = '0, port_value_override_value = '0;
  logic [N-1:0] port_toggle_override_enable = '0, input_enable_override_enable = '0;
  logic [N-1:0] input_enable_override_value = '0, analog_pad_line_in = '0;
  logic [N-1:0] ext_en = '1, ext_v = '0, r, w;
  logic [N-1:0] schmitt_output_tap, pad_in, pad_out, pad_oe, pad_pullup, pad_ie;
  logic [N-1:0] analog_pad_line_out, analog_pad_line_oe;
  int error_cnt = 0, comparisons = 0, cyc = 0, k;
  ppm_note_t notes[$], nt;
  ppm_port #(.N(N)) u_ppm_port (.*);
  ppm_pad_model #(.N(N)) u_ppm_pad_model (.*);
  always #25 pclk = ~pclk;
  ////////////////////////////////////////
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hf);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // ends when pready is seen high; if it never rises, only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // a read leaves its expected word for the monitor
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err = 0);
    notes.push_back(ppm_note_t'{err ? 3'd5 : 3'd0, e});
    apb(1'b0, a, '0);
  endtask
  // asks the monitor to look at one pad output vector
  task automatic pad(input logic [2:0] sel, input logic [N-1:0] e);
    @(posedge pclk);
    notes.push_back(ppm_note_t'{sel, 32'(e)});
    pad_chk <= 1'b1;
    @(posedge pclk);
    pad_chk <= 1'b0;
  endtask
  task automatic rand_ovr;
    {pullup_override_enable, pullup_override_value, direction_override_enable,
     direction_override_value, port_value_override_enable, port_value_override_value,
     input_enable_override_enable, input_enable_override_value}
      <= (8*N)'({$urandom, $urandom});
  endtask
  // monitor: each result that appears takes the oldest note
  always @(posedge pclk) begin
    if ((pready && !pwrite) || pad_chk) begin
      nt = notes.pop_front();
      case (nt.sel)
        3'd0, 3'd5: begin
          `CMP("prdata", nt.e, prdata)
          `CMP("pslverr", nt.sel == 3'd5, pslverr)
        end
        3'd1: `CMP("pad_pullup", nt.e[N-1:0], pad_pullup)
        3'd2: `CMP("pad_oe", nt.e[N-1:0], pad_oe)
        3'd3: `CMP("pad_out", nt.e[N-1:0], pad_out)
        default: `CMP("pad_ie", nt.e[N-1:0], pad_ie)
      endcase
    end
  end
  // a hang ends the run as a failure
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      test_done();
    end
  end
  ////////////////////////////////////////
  initial begin
    // a real falling edge at time zero, so the async reset takes hold at once
    presetn <= 1'b0;
    void'($urandom(32'h763f28c0));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // every direction/output/kill pattern, with unowned overrides wiggling
    port_toggle_override_enable <= N'($urandom);
    for (k = 0; k < 8; k++) begin
      rand_ovr();
      apb(1'b1, PPM_OFF_DIR, {32{k[2]}});
      apb(1'b1, PPM_OFF_OUT, {32{k[1]}});
      apb(1'b1, PPM_OFF_CTRL, {31'h0, k[0]});
      pad(3'd1, {N{k == 2}});
      pad(3'd2, {N{k[2]}});
      pad(3'd3, {N{k[1]}});
      rd(PPM_OFF_DIR, 32'({N{k[2]}}));
    end
    $display("test pattern table done");
    // second reset while pull-ups are on
    apb(1'b1, PPM_OFF_DIR, '0);
    apb(1'b1, PPM_OFF_CTRL, '0);
    apb(1'b1, PPM_OFF_OUT, '1);
    @(posedge pclk);
    presetn <= 1'b0;
    pad(3'd1, '0);
    @(posedge pclk);
    presetn <= 1'b1;
    rd(PPM_OFF_OUT, '0);
    $display("test reset done");
    // toggle through the sample address, with a random direction
    r = N'($urandom);
    w = N'($urandom);
    apb(1'b1, PPM_OFF_DIR, 32'(w));
    apb(1'b1, PPM_OFF_OUT, 32'(r));
    apb(1'b1, PPM_OFF_SAMPLE, 32'(w));
    rd(PPM_OFF_OUT, 32'(r ^ w));
    $display("test sample toggle done");
    // outside level and own driven level both reach the sample bits
    apb(1'b1, PPM_OFF_DIR, '0);
    ext_v <= r;
    repeat (3) @(posedge pclk);
    rd(PPM_OFF_SAMPLE, 32'(r));
    apb(1'b1, PPM_OFF_DIR, '1);
    apb(1'b1, PPM_OFF_OUT, 32'(w));
    repeat (3) @(posedge pclk);
    rd(PPM_OFF_SAMPLE, 32'(w));
    $display("test synchroniser done");
    // owned overrides against software state, clamp on every other round
    apb(1'b1, PPM_OFF_DIR, 32'(w));
    apb(1'b1, PPM_OFF_OUT, 32'(r));
    port_toggle_override_enable <= '0;
    alt_active <= '1;
    for (k = 0; k < 8; k++) begin
      rand_ovr();
      sleep_clamp_req <= k[0];
      @(posedge pclk);
      pad(3'd1, (pullup_override_enable & pullup_override_value)
                | (~pullup_override_enable & ~w & r));
      pad(3'd2, (direction_override_enable & direction_override_value)
                | (~direction_override_enable & w));
      pad(3'd3, (port_value_override_enable & port_value_override_value)
                | (~port_value_override_enable & r));
      pad(3'd4, (input_enable_override_enable & input_enable_override_value)
                | (~input_enable_override_enable & {N{~k[0]}}));
    end
    // toggle override held for exactly one edge
    port_toggle_override_enable <= w;
    @(posedge pclk);
    port_toggle_override_enable <= '0;
    rd(PPM_OFF_OUT, 32'(r ^ w));
    $display("test overrides done");
    // software clamp, interrupt-enabled pin kept live, flag made on wake
    alt_active <= '0;
    sleep_clamp_req <= 1'b0;
    ext_v <= '1;
    apb(1'b1, PPM_OFF_DIR, '0);
    // pin0 rise, pin2 fall, pin3 any change; only pin1 enabled
    apb(1'b1, PPM_OFF_IRQ, 32'h0063_3f02);
    apb(1'b1, PPM_OFF_CTRL, 1 << PPM_CTRL_SLEEP);
    pad(3'd4, N'(2));
    repeat (3) @(posedge pclk);
    rd(PPM_OFF_SAMPLE, 32'h2);
    apb(1'b1, PPM_OFF_CTRL, '0);
    repeat (3) @(posedge pclk);
    rd(PPM_OFF_IRQ, 32'h0063_0d02);
    $display("test sleep clamp done");
    // unmapped place and a write without the low byte strobe
    apb(1'b1, 12'h014, '1);
    rd(12'h014, '0, 1'b1);
    apb(1'b1, PPM_OFF_DIR, '1, 4'he);
    rd(PPM_OFF_DIR, '0);
    $display("test refusals done");
    test_done();
  end
endmodule
